// ==== hw/mds_pkg.sv ====
/*
 * Constants and types for the multicast data sharing block.
 * Assumes one 25 MHz clock and a 16-bit register port.
 */
package mds_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int SLOTS = 8;
  localparam int SLOT_W = 3;
  localparam int BUF_WORDS = 512;
  localparam int BUF_AW = 9;
  localparam int RXC_W = 11;

  // ****************************************
  // Register indexes on the register port
  // ****************************************
  localparam logic [7:0] A_STAT = 8'h00;
  localparam logic [7:0] A_CMD = 8'h01;
  localparam logic [7:0] A_IRQ = 8'h02;
  localparam logic [7:0] A_MASK = 8'h03;
  localparam logic [7:0] A_TRIG = 8'h04;
  localparam logic [7:0] A_ID = 8'h10;
  localparam logic [7:0] A_CTL = 8'h18;

  // ****************************************
  // Fields and reset values
  // ****************************************
  // Bits are numbered 1..16 from the MSB, so bit 7 is index 9
  localparam int ACT_BIT = 9;
  localparam int SCAN_EN_BIT = 9;
  localparam int SW_SHARE_BIT = 2;
  localparam logic [15:0] CMD_RST = 16'h0000;
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [15:0] ID_RST = 16'h0000;
  localparam logic [1:0] ROLE_PROD = 2'h1;
  localparam logic [1:0] ROLE_CONS = 2'h2;
  localparam logic [1:0] TRIG_TIMER = 2'h1;
  localparam logic [1:0] TRIG_LOGIC = 2'h2;
  localparam logic [1:0] TRIG_SCAN = 2'h3;
  localparam int EV_RX = 0;
  localparam int EV_TX = 1;
  localparam int EV_OVR = 2;
  localparam int NEV = 3;

  // ****************************************
  // Frame layout
  // ****************************************
  // Arbitrary values standing in for the group address and Ethertype
  localparam logic [47:0] GROUP_MAC = 48'h0300_0000_0001;
  localparam logic [15:0] SHARE_ETYPE = 16'h88B5;
  localparam logic [3:0] TX_HDR_LAST = 4'h9;
  localparam logic [RXC_W-1:0] RX_ET_HI = 11'h00C;
  localparam logic [RXC_W-1:0] RX_ET_LO = 11'h00D;
  localparam logic [RXC_W-1:0] RX_ID_HI = 11'h00E;
  localparam logic [RXC_W-1:0] RX_ID_LO = 11'h00F;
  localparam logic [RXC_W-1:0] RX_PAY = 11'h010;

  // ****************************************
  // Timing
  // ****************************************
  localparam int TIMER_UNIT_MS = 1000;
  localparam int CLK_KHZ = 25000;
  localparam int SEC_CYCLES = TIMER_UNIT_MS * CLK_KHZ;

  typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_HDR = 2'b01, TX_PAY = 2'b11} mds_tx_t;
  typedef enum logic [0:0] {DL_IDLE = 1'b0, DL_RUN = 1'b1} mds_dl_t;

endpackage : mds_pkg

// ==== hw/mds_buf_if.sv ====
/*
 * Interface between the framer and its consumer buffer store.
 * Assumes both ends share clk_i.
 */
`timescale 1ns/10ps
interface mds_buf_if;
  import mds_pkg::*;
  logic wr_en;
  logic [SLOT_W-1:0] wr_slot;
  logic [BUF_AW-1:0] wr_addr;
  logic [15:0] wr_data;
  logic [SLOT_W-1:0] rd_slot;
  logic [BUF_AW-1:0] rd_addr;
  logic [15:0] rd_data;
  modport writer(output wr_en, wr_slot, wr_addr, wr_data, rd_slot, rd_addr, input rd_data);
  modport store(input wr_en, wr_slot, wr_addr, wr_data, rd_slot, rd_addr, output rd_data);
endinterface : mds_buf_if

// ==== hw/mds_buf.sv ====
/*
 * One receive buffer per consumer slot, one word array for all.
 * Assumes writes and reads may hit the same slot in one cycle.
 */
`timescale 1ns/10ps
module mds_buf
  import mds_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Store side
  mds_buf_if.store b
);

  // ****************************************
  // Storage
  // ****************************************
  logic [15:0] mem [SLOTS*BUF_WORDS];
  wire [SLOT_W+BUF_AW-1:0] wr_idx = {b.wr_slot, b.wr_addr};
  wire [SLOT_W+BUF_AW-1:0] rd_idx = {b.rd_slot, b.rd_addr};

  // A new frame lands in place even while the old one is read out
  always_ff @(posedge clk_i) begin
    if (b.wr_en) begin
      mem[wr_idx] <= b.wr_data;
    end
  end

  // Asynchronous read; the framer registers what it takes
  assign b.rd_data = mem[rd_idx];

endmodule : mds_buf

// ==== hw/mds_top.sv ====
/*
 * Multicast data sharing framer: producer slots send raw-Ethertype
 * multicast frames, consumer slots keep the newest frame per identifier.
 * Assumes a MAC that takes byte streams, adds source address and CRC,
 * and performs collision retransmission on its own.
 */
// Notes on behaviour
// [RULE1] Produced set goes out multicast with identifier
// [RULE2] Accept frames only for configured identifiers
// [RULE3] Raw 802.3 frames under own Ethertype
// [RULE4] No listener check, acknowledgement or retry
// [RULE5] Group address keeps traffic on segment
// [RULE6] Several producers and consumers at once
// [RULE7] One buffer per identifier, filled during delivery
// [RULE8] Newer frame overwrites undelivered one
// [RULE9] Sharing on only with switch position 3
// [RULE10] Sharing sets multicast, one stream, no datagram
// [RULE11] Up to eight instances in any mix
// [RULE12] Controller limits logic producers at fast scan
// [RULE13] Active flag set while scan production enabled
// [RULE14] Scan production needs command enable bit
// [RULE15] Controller ties enable to a discrete output
// [RULE16] Trigger codes: 1 timer, 2 logic, 3 scan
// [RULE17] Unmatched frames dropped with no error
`timescale 1ns/10ps
module mds_top
  import mds_pkg::*;
#(
  parameter int SEC_CNT = SEC_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Straps and controller scan
  input wire logic [7:0] cfg_switch_block_i,
  input wire logic scan_pulse_i,
  // Transceiver and server controls
  output logic mcast_rx_en_o,
  output logic stream_one_conn_o,
  output logic dgram_srv_en_o,
  // Transmit stream to the MAC
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_last_o,
  input wire logic tx_ready_i,
  // Payload of the slot being produced
  output logic [SLOT_W-1:0] tx_slot_o,
  input wire logic pay_valid_i,
  input wire logic [7:0] pay_data_i,
  input wire logic pay_last_i,
  output logic pay_ready_o,
  // Receive stream from the MAC
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_last_i,
  // Delivery toward controller memory
  output logic dlv_valid_o,
  output logic [SLOT_W-1:0] dlv_slot_o,
  output logic [15:0] dlv_data_o,
  output logic dlv_last_o,
  input wire logic dlv_ready_i,
  // Interrupt
  output logic irq_o
);

  // ****************************************
  // Registers and mode decode
  // ****************************************
  logic [15:0] cmd_r;
  logic [NEV-1:0] irq_r;
  logic [NEV-1:0] mask_r;
  logic [15:0] id_r [SLOTS];
  logic [15:0] ctl_r [SLOTS];
  logic [15:0] rdata_r;
  logic [NEV-1:0] ev;

  wire share_en = cfg_switch_block_i[SW_SHARE_BIT]; // see [RULE9]
  wire scan_en = share_en & cmd_r[SCAN_EN_BIT]; // see [RULE14]
  wire [15:0] stat_w = 16'(scan_en) << ACT_BIT; // see [RULE13]
  wire wr_cmd = reg_wr_i && reg_addr_i == A_CMD;
  wire wr_irq = reg_wr_i && reg_addr_i == A_IRQ;
  wire wr_mask = reg_wr_i && reg_addr_i == A_MASK;
  wire wr_trig = reg_wr_i && reg_addr_i == A_TRIG;
  wire wr_id = reg_wr_i && reg_addr_i[7:3] == A_ID[7:3];
  wire wr_ctl = reg_wr_i && reg_addr_i[7:3] == A_CTL[7:3];
  wire [SLOT_W-1:0] rslot = reg_addr_i[SLOT_W-1:0];

  // Multicast on, one stream connection, no datagram server
  assign mcast_rx_en_o = share_en; // see [RULE10]
  assign stream_one_conn_o = share_en; // see [RULE10]
  assign dgram_srv_en_o = ~share_en; // see [RULE10]
  assign irq_o = |(irq_r & mask_r);

  // Read mux; unmapped indexes read zero
  logic [15:0] rmux;
  assign rmux = (reg_addr_i == A_STAT) ? stat_w :
                (reg_addr_i == A_CMD) ? cmd_r :
                (reg_addr_i == A_IRQ) ? 16'(irq_r) :
                (reg_addr_i == A_MASK) ? 16'(mask_r) :
                (reg_addr_i[7:3] == A_ID[7:3]) ? id_r[rslot] :
                (reg_addr_i[7:3] == A_CTL[7:3]) ? ctl_r[rslot] : 16'h0000;

  // Plain registers; status bits are write-one-to-clear, set wins
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_r <= CMD_RST;
      mask_r <= '0;
      irq_r <= '0;
      rdata_r <= 16'h0000;
    end else begin
      if (wr_cmd) cmd_r <= reg_wdata_i;
      if (wr_mask) mask_r <= reg_wdata_i[NEV-1:0];
      irq_r <= (irq_r & ~({NEV{wr_irq}} & reg_wdata_i[NEV-1:0])) | ev;
      if (reg_rd_i) rdata_r <= rmux;
    end
  end
  assign reg_rdata_o = rdata_r;

  // ****************************************
  // Timer divider: one pulse per second
  // ****************************************
  logic [31:0] div_r;
  wire sec_tick = div_r == 32'(SEC_CNT - 1);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) div_r <= 32'h0000_0000;
    else div_r <= sec_tick ? 32'h0000_0000 : div_r + 32'h0000_0001;
  end

  // ****************************************
  // Per-slot configuration and trigger logic
  // ****************************************
  logic [SLOTS-1:0] pend_r;
  logic [SLOTS-1:0] hit;
  logic [SLOTS-1:0] fresh_r;
  logic [15:0] rx_id_r;
  logic [SLOT_W-1:0] tx_sel;
  logic tx_grant;

  // Every slot can be set producer or consumer (role 0 or 3 is neither), so any mix of eight runs
  genvar g;
  for (g = 0; g < SLOTS; g++) begin : g_slot // see [RULE6] see [RULE11]
    logic [11:0] cnt_r;
    wire [1:0] role = ctl_r[g][1:0];
    wire [1:0] trig = ctl_r[g][3:2];
    wire [11:0] ivl = ctl_r[g][15:4];
    wire prod = share_en && role == ROLE_PROD;
    wire step = (trig == TRIG_TIMER && sec_tick) ||
                (trig == TRIG_SCAN && scan_pulse_i && scan_en); // see [RULE16] see [RULE14]
    wire due = prod && step && (cnt_r + 12'h001 >= ivl);
    // A logic trigger works with any option, on top of timer or scan
    wire kick = prod && wr_trig && reg_wdata_i[g]; // see [RULE16]
    wire done = tx_grant && tx_sel == SLOT_W'(g);
    assign hit[g] = share_en && role == ROLE_CONS && id_r[g] == rx_id_r; // see [RULE2]
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        id_r[g] <= ID_RST;
        ctl_r[g] <= CTL_RST;
        cnt_r <= 12'h000;
        pend_r[g] <= 1'b0;
      end else begin
        if (wr_id && rslot == SLOT_W'(g)) id_r[g] <= reg_wdata_i;
        if (wr_ctl && rslot == SLOT_W'(g)) ctl_r[g] <= reg_wdata_i;
        if (!prod) cnt_r <= 12'h000;
        else if (step) cnt_r <= due ? 12'h000 : cnt_r + 12'h001;
        pend_r[g] <= (pend_r[g] & ~done) | due | kick;
      end
    end
  end

  // ****************************************
  // Transmit: header then payload, one try only
  // ****************************************
  mds_tx_t tx_st_r;
  logic [3:0] hb_r;
  logic ov_r;
  logic [7:0] od_r;
  logic ol_r;
  logic [SLOT_W-1:0] slot_r;
  logic [15:0] tx_id;
  logic [7:0] hbyte;

  // Lowest pending slot wins the transmitter
  always_comb begin
    tx_sel = '0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (pend_r[i]) tx_sel = SLOT_W'(i);
    end
  end
  assign tx_grant = tx_st_r == TX_IDLE && |pend_r && (~ov_r | tx_ready_i);
  assign tx_id = id_r[slot_r];
  wire can_load = ~ov_r | tx_ready_i;

  // Group destination, Ethertype, identifier; no IP layer is ever added
  assign hbyte = (hb_r < 4'h6) ? GROUP_MAC[8'(47 - 8 * hb_r) -: 8] :
                 (hb_r == 4'h6) ? SHARE_ETYPE[15:8] :
                 (hb_r == 4'h7) ? SHARE_ETYPE[7:0] :
                 (hb_r == 4'h8) ? tx_id[15:8] : tx_id[7:0]; // see [RULE3] see [RULE5]
  assign pay_ready_o = tx_st_r == TX_PAY && can_load;

  // The frame is handed over once; no listener check and no resend
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_st_r <= TX_IDLE;
      hb_r <= 4'h0;
      ov_r <= 1'b0;
      od_r <= 8'h00;
      ol_r <= 1'b0;
      slot_r <= '0;
    end else begin
      if (tx_ready_i) ov_r <= 1'b0;
      case (tx_st_r)
        TX_IDLE: begin
          hb_r <= 4'h0;
          if (tx_grant) begin
            slot_r <= tx_sel;
            tx_st_r <= TX_HDR;
          end
        end
        TX_HDR: begin
          if (can_load) begin // see [RULE1]
            ov_r <= 1'b1;
            od_r <= hbyte;
            ol_r <= 1'b0;
            hb_r <= hb_r + 4'h1;
            if (hb_r == TX_HDR_LAST) tx_st_r <= TX_PAY;
          end
        end
        TX_PAY: begin
          if (can_load && pay_valid_i) begin // see [RULE1] see [RULE4]
            ov_r <= 1'b1;
            od_r <= pay_data_i;
            ol_r <= pay_last_i;
            if (pay_last_i) tx_st_r <= TX_IDLE;
          end
        end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end
  assign tx_valid_o = ov_r;
  assign tx_data_o = od_r;
  assign tx_last_o = ol_r;
  assign tx_slot_o = slot_r;

  // ****************************************
  // Receive parser
  // ****************************************
  mds_buf_if bif();
  logic [RXC_W-1:0] rc_r;
  logic [7:0] mac0_r;
  logic [15:0] et_r;
  logic [7:0] hi_r;
  logic [BUF_AW:0] wa_r;
  logic [BUF_AW:0] len_r [SLOTS];
  logic [SLOT_W-1:0] hsel;

  always_comb begin
    hsel = '0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (hit[i]) hsel = SLOT_W'(i);
    end
  end
  // Only group-addressed frames of our Ethertype for a known identifier
  wire rx_ok = mac0_r[0] && et_r == SHARE_ETYPE && |hit; // see [RULE2] see [RULE17]
  wire in_pay = rx_valid_i && rc_r >= RX_PAY && rx_ok;
  wire odd = rc_r[0];
  wire room = ~wa_r[BUF_AW];
  wire commit = in_pay && rx_last_i;

  // Bytes pair high first; a lone last byte is padded with zero
  assign bif.wr_en = in_pay && room && (odd || rx_last_i);
  assign bif.wr_slot = hsel;
  assign bif.wr_addr = wa_r[BUF_AW-1:0];
  assign bif.wr_data = odd ? {hi_r, rx_data_i} : {rx_data_i, 8'h00};

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rc_r <= '0;
      mac0_r <= 8'h00;
      et_r <= 16'h0000;
      rx_id_r <= 16'h0000;
      hi_r <= 8'h00;
      wa_r <= '0;
    end else if (rx_valid_i) begin
      rc_r <= rx_last_i ? '0 : (rc_r == '1 ? rc_r : rc_r + 1'b1);
      if (rc_r == '0) mac0_r <= rx_data_i;
      if (rc_r == RX_ET_HI) et_r[15:8] <= rx_data_i;
      if (rc_r == RX_ET_LO) et_r[7:0] <= rx_data_i;
      if (rc_r == RX_ID_HI) rx_id_r[15:8] <= rx_data_i;
      if (rc_r == RX_ID_LO) rx_id_r[7:0] <= rx_data_i;
      if (!odd) hi_r <= rx_data_i;
      if (rx_last_i) wa_r <= '0;
      else if (bif.wr_en) wa_r <= wa_r + 1'b1;
    end
  end

  // ****************************************
  // Delivery of newest frames to the controller
  // ****************************************
  mds_dl_t dl_st_r;
  logic [SLOT_W-1:0] ds_r;
  logic [BUF_AW:0] ra_r;
  logic dv_r;
  logic [15:0] dd_r;
  logic dlst_r;
  logic [SLOT_W-1:0] fsel;

  always_comb begin
    fsel = '0;
    for (int i = SLOTS - 1; i >= 0; i--) begin
      if (fresh_r[i]) fsel = SLOT_W'(i);
    end
  end
  wire dl_start = dl_st_r == DL_IDLE && |fresh_r;
  wire d_load = ~dv_r | dlv_ready_i;
  wire dl_end = ra_r + 1'b1 >= len_r[ds_r];
  assign bif.rd_slot = ds_r;
  assign bif.rd_addr = ra_r[BUF_AW-1:0];

  // Events: frame kept, frame sent, undelivered frame replaced
  assign ev[EV_RX] = commit;
  assign ev[EV_TX] = tx_st_r == TX_PAY && can_load && pay_valid_i && pay_last_i;
  assign ev[EV_OVR] = commit && (fresh_r[hsel] ||
                      (ds_r == hsel && (dl_st_r == DL_RUN || dv_r))); // see [RULE8]

  // Fresh flag: a new commit beats the clear taken at start of delivery
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fresh_r <= '0;
      for (int i = 0; i < SLOTS; i++) len_r[i] <= '0;
      dl_st_r <= DL_IDLE;
      ds_r <= '0;
      ra_r <= '0;
      dv_r <= 1'b0;
      dd_r <= 16'h0000;
      dlst_r <= 1'b0;
    end else begin
      fresh_r <= (fresh_r & ~(SLOTS'(dl_start) << fsel)) |
                 (SLOTS'(commit) << hsel); // see [RULE7] see [RULE8]
      if (commit) len_r[hsel] <= wa_r + (room ? 1'b1 : 1'b0);
      if (dlv_ready_i) dv_r <= 1'b0;
      case (dl_st_r)
        DL_IDLE: begin
          ra_r <= '0;
          if (dl_start) begin
            ds_r <= fsel;
            dl_st_r <= DL_RUN;
          end
        end
        DL_RUN: begin
          if (d_load) begin // see [RULE7]
            dv_r <= 1'b1;
            dd_r <= bif.rd_data;
            dlst_r <= dl_end;
            ra_r <= ra_r + 1'b1;
            if (dl_end) dl_st_r <= DL_IDLE;
          end
        end
        default: dl_st_r <= DL_IDLE;
      endcase
    end
  end
  assign dlv_valid_o = dv_r;
  assign dlv_slot_o = ds_r;
  assign dlv_data_o = dd_r;
  assign dlv_last_o = dlst_r;

  // Single buffer store for all consumer slots
  mds_buf u_buf (
    .clk_i(clk_i),
    .b(bif)
  );

endmodule : mds_top

// ==== tb/mds_top_monitor.sv ====
/* Port checker for mds_top: server controls, stream holds, active flag.
   Assumes one clock domain and an active-high reset. */
`timescale 1ns/10ps
module mds_top_monitor
  import mds_pkg::*;
#(
  parameter int SEC_CNT = SEC_CYCLES
) (
  // Clock, reset and register port
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  // Switch and server controls
  input wire logic [7:0] cfg_switch_block_i,
  input wire logic mcast_rx_en_o,
  input wire logic stream_one_conn_o,
  input wire logic dgram_srv_en_o,
  // Streams
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_last_o,
  input wire logic tx_ready_i,
  input wire logic [SLOT_W-1:0] tx_slot_o,
  input wire logic dlv_valid_o,
  input wire logic [SLOT_W-1:0] dlv_slot_o,
  input wire logic [15:0] dlv_data_o,
  input wire logic dlv_ready_i
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire sh = cfg_switch_block_i[SW_SHARE_BIT];
  // ****************************************
  // Server controls follow the share switch
  // ****************************************
  property p_mcast;
    mcast_rx_en_o == sh;
  endproperty
  a_mcast: assert property (p_mcast) else $error("multicast enable wrong");
  property p_stream;
    stream_one_conn_o == sh;
  endproperty
  a_stream: assert property (p_stream) else $error("stream limit wrong");
  property p_dgram;
    dgram_srv_en_o == !sh;
  endproperty
  a_dgram: assert property (p_dgram) else $error("datagram enable wrong");
  // ****************************************
  // Streams hold while stalled; frames open with the group address
  // ****************************************
  property p_txhold;
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o);
  endproperty
  a_txhold: assert property (p_txhold) else $error("tx byte dropped");
  property p_grp;
    $rose(tx_valid_o) |-> tx_data_o == GROUP_MAC[47:40];
  endproperty
  a_grp: assert property (p_grp) else $error("frame not group addressed");
  property p_slot;
    tx_valid_o && !(tx_last_o && tx_ready_i) |=> $stable(tx_slot_o);
  endproperty
  a_slot: assert property (p_slot) else $error("slot moved in frame");
  property p_dlvhold;
    dlv_valid_o && !dlv_ready_i |=> dlv_valid_o && $stable(dlv_data_o) && $stable(dlv_slot_o);
  endproperty
  a_dlvhold: assert property (p_dlvhold) else $error("delivery word dropped");
  // Active flag can never show with the switch off
  property p_act;
    reg_rd_i && reg_addr_i == A_STAT && !sh |=> !reg_rdata_o[ACT_BIT];
  endproperty
  a_act: assert property (p_act) else $error("active flag with switch off");
endmodule : mds_top_monitor

bind mds_top mds_top_monitor #(.SEC_CNT(SEC_CNT)) i_mon (.clk_i, .rst_i, .reg_addr_i, .reg_rd_i,
  .reg_rdata_o, .cfg_switch_block_i, .mcast_rx_en_o, .stream_one_conn_o, .dgram_srv_en_o,
  .tx_valid_o, .tx_data_o, .tx_last_o, .tx_ready_i, .tx_slot_o, .dlv_valid_o, .dlv_slot_o,
  .dlv_data_o, .dlv_ready_i);

// ==== tb/mds_peer.sv ====
/* Peer station model: sends frames to the block, swallows its frames.
   Assumes the bench calls send and reads got and frames. */
`timescale 1ns/10ps
module mds_peer (
  // Clock and pacing
  input wire logic clk_i,
  input wire logic stall_i,
  // Frames toward the block
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_last_o,
  // Frames from the block
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_last_i,
  output logic tx_ready_o
);
  logic [7:0] got[$];
  int frames = 0;
  logic ph_r = 1'b0;
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    rx_last_o = 1'b0;
  end
  // Slow mode takes a byte only every other cycle; nothing is ever answered
  assign tx_ready_o = ~stall_i | ph_r;
  always @(posedge clk_i) begin
    ph_r <= ~ph_r;
    if (tx_valid_i && tx_ready_o) begin
      got.push_back(tx_data_i);
      if (tx_last_i) frames++;
    end
  end
  // Group address, own source, share type, identifier, payload
  task automatic send(input logic [15:0] id, input logic [7:0] pay[$]);
    logic [7:0] f[$];
    f = {8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
    f = {f, 8'h88, 8'hB5, id[15:8], id[7:0], pay};
    foreach (f[i]) begin
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_data_o <= f[i];
      rx_last_o <= (i == f.size() - 1);
    end
    // Released line shows the inverse so a stale byte is never taken
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_last_o <= 1'b0;
    rx_data_o <= ~f[f.size() - 1];
  endtask : send
endmodule : mds_peer

// ==== tb/multicast_data_sharing_test.sv ====
/* Self-checking bench for mds_top through its register port and streams.
   Assumes mds_peer on the network side and the bound port checker. */
`timescale 1ns/10ps
module multicast_data_sharing_test;
  import mds_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] sw_r = 8'h04;
  logic scan_r = 1'b0;
  logic stall_r = 1'b1;
  logic dlv_rdy_r = 1'b1;
  logic pidx_r = 1'b0;
  logic [15:0] reg_rdata_o, dlv_data_o, d;
  logic tx_valid_o, tx_last_o, tx_ready_i, pay_ready_o, rx_valid_i, rx_last_i, dlv_valid_o, irq_o;
  logic [7:0] tx_data_o, rx_data_i;
  logic [7:0] exp1[12] = '{8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h88, 8'hB5, 8'h12,
    8'h34, 8'hAB, 8'hCD};
  logic [15:0] dq[$];
  int errors = 0;
  int checks_done = 0;
  int f0;
  int nl = 0;
  logic dlv_last_o;
  mds_top #(.SEC_CNT(20)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .cfg_switch_block_i(sw_r), .scan_pulse_i(scan_r), .mcast_rx_en_o(), .stream_one_conn_o(),
    .dgram_srv_en_o(), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_last_o(tx_last_o),
    .tx_ready_i(tx_ready_i), .tx_slot_o(), .pay_valid_i(1'b1),
    .pay_data_i(pidx_r ? 8'hCD : 8'hAB), .pay_last_i(pidx_r), .pay_ready_o(pay_ready_o),
    .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_last_i(rx_last_i),
    .dlv_valid_o(dlv_valid_o), .dlv_slot_o(), .dlv_data_o(dlv_data_o), .dlv_last_o(dlv_last_o),
    .dlv_ready_i(dlv_rdy_r), .irq_o(irq_o));
  mds_peer i_peer (.clk_i(clk_i), .stall_i(stall_r), .rx_valid_o(rx_valid_i),
    .rx_data_o(rx_data_i), .rx_last_o(rx_last_i), .tx_valid_i(tx_valid_o),
    .tx_data_i(tx_data_o), .tx_last_i(tx_last_o), .tx_ready_o(tx_ready_i));
  initial begin
    forever #20 clk_i = ~clk_i;
  end
  // Two-byte payload source and delivery sink
  always @(posedge clk_i) begin
    if (pay_ready_o) pidx_r <= ~pidx_r;
    if (dlv_valid_o && dlv_rdy_r) dq.push_back(dlv_data_o);
    if (dlv_valid_o && dlv_rdy_r && dlv_last_o) nl++;
  end
  // ****************************************
  // Register port and compare tasks
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rd
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk_i);
      scan_r <= 1'b1;
      @(posedge clk_i);
      scan_r <= 1'b0;
      repeat (40) @(posedge clk_i);
    end
  endtask : pulses
  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  // Watchdog sized well above the whole sequence
  initial begin
    repeat (20000) @(posedge clk_i);
    errors++;
    give_verdict();
  end
  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(A_CMD); chk(d, CMD_RST);
    rd(A_CTL); chk(d, CTL_RST);
    rd(8'h3F); chk(d, 16'h0000);
    $display("Done: reset values");
    // Active flag needs both the switch and the command bit
    wr(A_CMD, 16'h0200);
    rd(A_STAT); chk(d & 16'h0200, 16'h0200);
    @(posedge clk_i);
    sw_r <= 8'hFB;
    rd(A_STAT); chk(d & 16'h0200, 16'h0000);
    @(posedge clk_i);
    sw_r <= 8'h04;
    wr(A_CMD, 16'h0000);
    rd(A_STAT); chk(d & 16'h0200, 16'h0000);
    $display("Done: active flag");
    // Logic-triggered frame with a stalling peer, then the interrupt path
    wr(A_ID, 16'h1234);
    wr(A_CTL, 16'h0009);
    i_peer.got.delete();
    wr(A_TRIG, 16'h0001);
    for (int k = 0; k < 400 && i_peer.frames < 1; k++) @(posedge clk_i);
    chk(16'(i_peer.got.size()), 16'd12);
    foreach (exp1[i]) chk({8'h00, i_peer.got[i]}, {8'h00, exp1[i]});
    rd(A_IRQ); chk(d & 16'h0002, 16'h0002);
    wr(A_MASK, 16'h0000);
    #1 chk({15'h0000, irq_o}, 16'h0000);
    wr(A_MASK, 16'h0002);
    #1 chk({15'h0000, irq_o}, 16'h0001);
    wr(A_IRQ, 16'h0007);
    #1 chk({15'h0000, irq_o}, 16'h0000);
    $display("Done: logic production");
    // Matching frame is kept and delivered, odd byte padded
    wr(A_ID + 8'h01, 16'h0042);
    wr(A_CTL + 8'h01, 16'h0002);
    i_peer.send(16'h0042, '{8'h11, 8'h22, 8'h33});
    for (int k = 0; k < 100 && dq.size() < 2; k++) @(posedge clk_i);
    chk(dq[0], 16'h1122);
    chk(dq[1], 16'h3300);
    chk(16'(nl), 16'd1);
    rd(A_IRQ); chk(d & 16'h0001, 16'h0001);
    wr(A_IRQ, 16'h0007);
    // Unknown identifier leaves no trace
    dq.delete();
    i_peer.send(16'h0043, '{8'h44, 8'h55});
    repeat (20) @(posedge clk_i);
    chk(16'(dq.size()), 16'd0);
    rd(A_IRQ); chk(d & 16'h0001, 16'h0000);
    $display("Done: consumer");
    // Second frame lands while the first is still being delivered
    @(posedge clk_i);
    dlv_rdy_r <= 1'b0;
    i_peer.send(16'h0042, '{8'h55, 8'h66});
    i_peer.send(16'h0042, '{8'h77, 8'h88});
    @(posedge clk_i);
    dlv_rdy_r <= 1'b1;
    for (int k = 0; k < 100 && dq.size() < 2; k++) @(posedge clk_i);
    chk(dq[dq.size() - 1], 16'h7788);
    rd(A_IRQ); chk(d & 16'h0004, 16'h0004);
    $display("Done: overwrite");
    // Scan trigger every second scan, gated by the command bit
    wr(A_CTL, 16'h002D);
    f0 = i_peer.frames;
    pulses(4);
    chk(16'(i_peer.frames - f0), 16'd0);
    wr(A_CMD, 16'h0200);
    pulses(4);
    chk(16'(i_peer.frames - f0), 16'd2);
    wr(A_CMD, 16'h0000);
    // One-second timer, shortened to 20 cycles
    @(posedge clk_i);
    stall_r <= 1'b0;
    f0 = i_peer.frames;
    wr(A_CTL, 16'h0015);
    repeat (200) @(posedge clk_i);
    wr(A_CTL, 16'h0000);
    chk({15'h0000, (i_peer.frames - f0) >= 5}, 16'h0001);
    $display("Done: scan and timer production");
    give_verdict();
  end
endmodule : multicast_data_sharing_test
